// File: core/phy_pair_pkg.sv
// shared constants, state types and symbol functions of the pair mapping block
// assumes one 20 MHz core clock and line levels already sliced to five-level codes
package phy_pair_pkg;

    // speed selection from the link controller
    localparam logic [1:0] SPEED_10   = 2'h0;
    localparam logic [1:0] SPEED_100  = 2'h1;
    localparam logic [1:0] SPEED_1000 = 2'h2;

    // five-level line codes, 0..4 stand for -2..+2
    localparam logic [2:0] LVL_LO  = 3'h1;
    localparam logic [2:0] LVL_MID = 3'h2;
    localparam logic [2:0] LVL_HI  = 3'h3;
    localparam logic [2:0] LVL_MAX = 3'h4;

    localparam int NUM_LANES = 4;

    // gigabit side-stream scrambler, master and slave use different taps
    localparam int          SCR_W      = 33;
    localparam int          MASTER_TAP = 13;
    localparam int          SLAVE_TAP  = 20;
    localparam logic [32:0] SEED_BASE  = 33'h05a5ac3c3; // arbitrary, only needs to be non-zero
    localparam logic [9:0]  SYM_LIMIT  = 10'h1ff;       // largest legal nine-bit symbol

    // ten megabit framing
    localparam logic [7:0] SFD_BYTE     = 8'hd5;
    localparam logic [7:0] SFD_INVERTED = 8'h2a;

    // pair skew tolerance, counted in 8 ns gigabit symbols
    localparam int SKEW_NOM_NS   = 50;
    localparam int SKEW_TOL_NS   = 10;
    localparam int SYM_PERIOD_NS = 8;
    localparam int DESKEW_DEPTH  = (SKEW_NOM_NS + SKEW_TOL_NS + SYM_PERIOD_NS - 1) / SYM_PERIOD_NS;

    // idle-stream training
    localparam logic [5:0] COLLECT_SYMS = 6'h21;  // 33 bits load the descrambler
    localparam logic [5:0] LOCK_SYMS    = 6'h10;  // matching idles before data is passed
    // hunt word: [0] crossover guess, [2:1] order mask, [6:3] polarity, [18:7] skews
    localparam int CFG_ORD  = 1;
    localparam int CFG_POL  = 3;
    localparam int CFG_SKEW = 7;
    localparam int CFG_W    = 19;

    // synthesizer phase: 25 steps of the 125 MHz phase make 5 of 25 MHz and 2 of 10 MHz
    localparam logic [4:0] PLL_LAST   = 5'h18;
    localparam logic [4:0] DIV_25     = 5'h05;
    localparam logic [4:0] TICK10_A   = 5'h00;
    localparam logic [4:0] TICK10_B   = 5'h0c;

    typedef enum logic [1:0] {H_COLLECT, H_VERIFY, H_LOCKED} hunt_e;
    typedef enum logic [1:0] {R_IDLE, R_HUNT, R_DATA} rx10_e;

    function automatic logic [32:0] scr_step(input logic [32:0] s, input int tap);
        return {s[31:0], s[32] ^ s[tap - 1]};
    endfunction

    function automatic logic [32:0] seed_from_addr(input logic [4:0] addr);
        return SEED_BASE ^ {addr, 3'h0, addr, 3'h0, addr, 3'h0, addr, 4'h0};
    endfunction

    // nine-bit symbol to four base-five digits, lane one in the low digit
    function automatic logic [11:0] sym_to_lvls(input logic [8:0] s);
        logic [11:0] lv;
        logic [9:0]  v;
        v = {1'b0, s};
        for (int k = 0; k < NUM_LANES; k++) begin
            lv[k*3 +: 3] = 3'(v % 10'd5);
            v = v / 10'd5;
        end
        return lv;
    endfunction

    // digits back to a value; an illegal digit gives an out-of-range result
    function automatic logic [9:0] lvls_to_val(input logic [11:0] lv);
        logic [9:0] v;
        v = 10'h000;
        for (int k = NUM_LANES - 1; k >= 0; k--) begin
            if (lv[k*3 +: 3] > LVL_MAX) begin
                return 10'h3ff;
            end
            v = 10'(v * 10'd5 + {7'h00, lv[k*3 +: 3]});
        end
        return v;
    endfunction

endpackage

// File: core/phy_pair_core.sv
// pair mapping, alignment, polarity and scrambling core with its transmit FIFO
// assumes sliced line levels and the recovered symbol strobe arrive on core_clk
//
// Functional notes
// - ten megabit receive drops the seven preamble bytes, frame starts at SFD
// - receive clock strobe keeps running through idle gaps at ten megabit
// - gigabit transmit scrambles each byte to nine bits, then four five-level digits
// - transmit scrambler seed is derived from the management address
// - gigabit receive resolves seed, skew, order and polarity from idles first
// - gigabit receive turns digits back to nine bits and descrambles to bytes
// - auto crossover is on by default, the disable input turns it off
// - with auto off, the force input picks straight or crossover
// - auto mode senses partner mapping and takes the complementary one
// - crossover swaps pairs one/two and three/four; slow speeds use two pairs
// - gigabit receive restores the logical channel order automatically
// - gigabit receive deskews pairs up to 60 ns of difference
// - inverted pair polarity is corrected at every speed
// - a gigabit slave transmits on the recovered receive symbol strobe
// - 125, 25 and 10 MHz strobes come from the reference synthesizer phase
`timescale 1ns/1ps

module phy_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    // one spare pointer bit tells full from empty
    assign in_ready  = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign out_valid = wr_r != rd_r;
    assign out_data  = mem[rd_r[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_r + (AW+1)'(push);
            rd_r <= rd_r + (AW+1)'(pop);
        end
    end
endmodule

module phy_pair_core
    import phy_pair_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       pll_tick,
    input  wire logic [1:0] speed,
    input  wire logic       is_slave,
    input  wire logic [4:0] phy_addr,
    input  wire logic       auto_xover_off,
    input  wire logic       force_xover,
    input  wire logic       rx_sym_tick,
    input  wire logic [2:0] line_pair_one_rx,
    input  wire logic [2:0] line_pair_two_rx,
    input  wire logic [2:0] line_pair_three_rx,
    input  wire logic [2:0] line_pair_four_rx,
    output logic      [2:0] line_pair_one_tx,
    output logic      [2:0] line_pair_two_tx,
    output logic      [2:0] line_pair_three_tx,
    output logic      [2:0] line_pair_four_tx,
    input  wire logic       mac_tx_valid,
    input  wire logic [7:0] mac_tx_data,
    output logic            mac_tx_ready,
    output logic            mac_rx_valid,
    output logic      [7:0] mac_rx_data,
    output logic            mac_rx_clk_tick,
    output logic            xover_active,
    output logic            gig_locked
);
    // synthesizer strobes, all derived from the one reference phase
    logic [4:0] pll_cnt_r;
    wire        tick_125 = pll_tick;
    wire        tick_25  = pll_tick && (pll_cnt_r % DIV_25 == 5'h00);
    wire        tick_10  = pll_tick && (pll_cnt_r == TICK10_A || pll_cnt_r == TICK10_B);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pll_cnt_r <= 5'h00;
        end else if (pll_tick) begin
            pll_cnt_r <= (pll_cnt_r == PLL_LAST) ? 5'h00 : pll_cnt_r + 5'h01;
        end
    end

    // speed decode and pair mapping selection
    wire gig    = speed == SPEED_1000;
    wire bit_en = (speed == SPEED_10) ? tick_10 : tick_25;
    logic [CFG_W-1:0] cfg_r;
    logic             auto_x_r;
    wire  xsel = auto_xover_off ? force_xover : (gig ? cfg_r[0] : auto_x_r);
    wire  [1:0] lane_mask = {cfg_r[CFG_ORD+1], cfg_r[CFG_ORD] ^ xsel};

    // slow speeds: activity on our own transmit pair means the partner is straight too
    wire act_one = line_pair_one_rx != LVL_MID;
    wire act_two = line_pair_two_rx != LVL_MID;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            auto_x_r <= 1'b0;
        end else if (!gig && bit_en && act_one) begin
            auto_x_r <= 1'b1;
        end else if (!gig && bit_en && act_two) begin
            auto_x_r <= 1'b0;
        end
    end

    // per-pair delay lines, newest symbol at tap zero
    logic [2:0] raw_lane [NUM_LANES];
    logic [2:0] dly_r    [NUM_LANES][DESKEW_DEPTH];
    logic [2:0] fixed    [NUM_LANES];
    logic [2:0] logical  [NUM_LANES];
    assign raw_lane[0] = line_pair_one_rx;
    assign raw_lane[1] = line_pair_two_rx;
    assign raw_lane[2] = line_pair_three_rx;
    assign raw_lane[3] = line_pair_four_rx;

    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        wire [2:0] tap = dly_r[g][cfg_r[CFG_SKEW + 3*g +: 3]];
        assign fixed[g]   = cfg_r[CFG_POL + g] ? LVL_MAX - tap : tap;
        assign logical[g] = fixed[2'(g) ^ lane_mask];

        always_ff @(posedge core_clk) begin
            if (rx_sym_tick) begin
                dly_r[g][0] <= raw_lane[g];
                for (int d = 1; d < DESKEW_DEPTH; d++) begin
                    dly_r[g][d] <= dly_r[g][d-1];
                end
            end
        end
    end

    // receive symbol decode and descrambler prediction
    hunt_e       hunt_r;
    logic [32:0] desc_r;
    logic [5:0]  hcnt_r;
    wire  [9:0]  rx_val   = lvls_to_val({logical[3], logical[2], logical[1], logical[0]});
    wire         sym_ok   = rx_val <= SYM_LIMIT;
    wire  [8:0]  rx_sym   = rx_val[8:0];
    wire  [32:0] pred     = scr_step(desc_r, is_slave ? MASTER_TAP : SLAVE_TAP);
    wire  [7:0]  rx_byte  = rx_sym[7:0] ^ pred[7:0];
    wire         rx_act   = rx_sym[8] ^ pred[8];
    wire         idle_hit = sym_ok && rx_sym == pred[8:0];

    // hunt: load the remote seed, check idles, otherwise try the next alignment
    always_ff @(posedge core_clk) begin
        if (rst || !gig) begin
            hunt_r <= H_COLLECT;
            hcnt_r <= 6'h00;
            cfg_r  <= '0;
            desc_r <= '0;
        end else if (rx_sym_tick) begin
            case (hunt_r)
                H_COLLECT: begin
                    desc_r <= {desc_r[31:0], rx_sym[0]};
                    hcnt_r <= hcnt_r + 6'h01;
                    if (hcnt_r == COLLECT_SYMS - 6'h01) begin
                        hunt_r <= H_VERIFY;
                        hcnt_r <= 6'h00;
                    end
                end
                H_VERIFY: begin
                    desc_r <= pred;
                    hcnt_r <= hcnt_r + 6'h01;
                    if (!idle_hit) begin
                        hunt_r <= H_COLLECT;
                        hcnt_r <= 6'h00;
                        cfg_r  <= cfg_r + CFG_W'(1);
                    end else if (hcnt_r == LOCK_SYMS - 6'h01) begin
                        hunt_r <= H_LOCKED;
                    end
                end
                H_LOCKED: begin
                    desc_r <= pred;
                    if (!sym_ok) begin
                        hunt_r <= H_COLLECT;
                        hcnt_r <= 6'h00;
                        cfg_r  <= cfg_r + CFG_W'(1);
                    end
                end
                default: begin
                    hunt_r <= H_COLLECT;
                end
            endcase
        end
    end

    // slow-speed receive: strip preamble, align on SFD, learn polarity from it
    rx10_e      rx10_r;
    logic [7:0] sh_r;
    logic [2:0] bcnt_r;
    logic       pol10_r;
    wire  [2:0] lvl10   = xsel ? line_pair_one_rx : line_pair_two_rx;
    wire        carrier = lvl10 != LVL_MID;
    wire  [7:0] sh_nxt  = {lvl10 > LVL_MID, sh_r[7:1]};
    wire        sfd_hit = sh_nxt == SFD_BYTE || sh_nxt == SFD_INVERTED;
    wire        emit10  = bit_en && carrier &&
                          ((rx10_r == R_HUNT && sfd_hit) || (rx10_r == R_DATA && bcnt_r == 3'h7));
    wire  [7:0] byte10  = (rx10_r == R_HUNT) ? SFD_BYTE : sh_nxt ^ {8{pol10_r}};

    always_ff @(posedge core_clk) begin
        if (rst || gig) begin
            rx10_r  <= R_IDLE;
            sh_r    <= 8'h00;
            bcnt_r  <= 3'h0;
            pol10_r <= 1'b0;
        end else if (bit_en) begin
            sh_r   <= sh_nxt;
            bcnt_r <= bcnt_r + 3'h1;
            case (rx10_r)
                R_IDLE: begin
                    rx10_r <= carrier ? R_HUNT : R_IDLE;
                end
                R_HUNT: begin
                    if (!carrier) begin
                        rx10_r <= R_IDLE;
                    end else if (sfd_hit) begin
                        rx10_r  <= R_DATA;
                        pol10_r <= sh_nxt == SFD_INVERTED;
                        bcnt_r  <= 3'h0;
                    end
                end
                R_DATA: begin
                    rx10_r <= carrier ? R_DATA : R_IDLE;
                end
                default: begin
                    rx10_r <= R_IDLE;
                end
            endcase
        end
    end

    // receive outputs; the clock strobe is never gated by frames
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mac_rx_valid    <= 1'b0;
            mac_rx_data     <= 8'h00;
            mac_rx_clk_tick <= 1'b0;
        end else begin
            mac_rx_clk_tick <= gig ? rx_sym_tick : bit_en;
            mac_rx_valid    <= gig ? (rx_sym_tick && hunt_r == H_LOCKED && sym_ok && rx_act)
                                   : emit10;
            if (gig && rx_sym_tick) begin
                mac_rx_data <= rx_byte;
            end else if (!gig && emit10) begin
                mac_rx_data <= byte10;
            end
        end
    end

    // transmit FIFO toward the line; the line side drains it at symbol or bit rate
    logic        f_valid;
    logic [7:0]  f_data;
    logic [32:0] tx_scr_r;
    logic [7:0]  ser_r;
    logic [3:0]  tbits_r;
    logic [2:0]  tx_lvl_r [NUM_LANES];
    wire         tx_sym_en = is_slave ? rx_sym_tick : tick_125;
    wire         f_ready   = gig ? tx_sym_en : (bit_en && tbits_r == 4'h0);
    wire         take      = f_ready && f_valid;
    wire  [8:0]  tx_sym    = {tx_scr_r[8] ^ take, (take ? f_data : 8'h00) ^ tx_scr_r[7:0]};
    wire  [11:0] tx_lv     = sym_to_lvls(tx_sym);

    phy_tx_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (mac_tx_valid),
        .in_data   (mac_tx_data),
        .in_ready  (mac_tx_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    // scrambler state only moves on transmit symbols; seed is reloaded by reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_scr_r <= seed_from_addr(phy_addr);
        end else if (gig && tx_sym_en) begin
            tx_scr_r <= scr_step(tx_scr_r, is_slave ? SLAVE_TAP : MASTER_TAP);
        end
    end

    // transmit levels: four digits at gigabit, one serial pair otherwise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ser_r   <= 8'h00;
            tbits_r <= 4'h0;
            for (int k = 0; k < NUM_LANES; k++) begin
                tx_lvl_r[k] <= LVL_MID;
            end
        end else if (gig) begin
            tbits_r <= 4'h0;
            if (tx_sym_en) begin
                for (int k = 0; k < NUM_LANES; k++) begin
                    tx_lvl_r[k] <= tx_lv[k*3 +: 3];
                end
            end
        end else begin
            // unused pairs go quiet at once, not on the next bit strobe after gigabit
            for (int k = 1; k < NUM_LANES; k++) begin
                tx_lvl_r[k] <= LVL_MID;
            end
            if (bit_en && tbits_r != 4'h0) begin
                tx_lvl_r[0] <= ser_r[0] ? LVL_HI : LVL_LO;
                ser_r       <= {1'b0, ser_r[7:1]};
                tbits_r     <= tbits_r - 4'h1;
            end else if (bit_en) begin
                tx_lvl_r[0] <= LVL_MID;
                if (f_valid) begin
                    ser_r   <= f_data;
                    tbits_r <= 4'h8;
                end
            end
        end
    end

    // crossover applied on the way out; the partner sees the complement of its own map
    assign line_pair_one_tx   = tx_lvl_r[{1'b0, xsel}];
    assign line_pair_two_tx   = tx_lvl_r[{1'b0, ~xsel}];
    assign line_pair_three_tx = tx_lvl_r[{1'b1, xsel}];
    assign line_pair_four_tx  = tx_lvl_r[{1'b1, ~xsel}];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            xover_active <= 1'b0;
            gig_locked   <= 1'b0;
        end else begin
            xover_active <= xsel;
            gig_locked   <= hunt_r == H_LOCKED;
        end
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_sfd_leads_frame: assert property ((rx10_r == R_HUNT) && emit10 |=> mac_rx_data == SFD_BYTE)
        else $error("slow frame did not start with SFD");
    a_rx_clk_runs: assert property (!gig && bit_en && $stable(speed) |=> mac_rx_clk_tick)
        else $error("receive clock strobe stopped");
    a_tx_sym_map: assert property (gig && tx_sym_en |=> tx_lvl_r[0] == $past(tx_lv[2:0]))
        else $error("transmit digit does not match scrambled symbol");
    a_seed_at_reset: assert property ($fell(rst) |-> tx_scr_r == seed_from_addr($past(phy_addr)))
        else $error("scrambler seed not taken from address");
    a_lock_after_verify: assert property ($rose(gig_locked) |-> $past(hunt_r, 2) == H_VERIFY)
        else $error("lock without idle verification");
    a_forced_map: assert property (auto_xover_off ##1 auto_xover_off |-> xover_active == $past(force_xover))
        else $error("forced mapping ignored");
    a_slow_pairs_idle: assert property (!gig && $past(!gig) ##1 !gig |-> line_pair_three_tx == LVL_MID && line_pair_four_tx == LVL_MID)
        else $error("unused pairs driven at slow speed");
    a_slave_tx_clock: assert property (gig && is_slave && !rx_sym_tick && $stable(speed) |=> $stable(tx_scr_r))
        else $error("slave transmitted off the recovered strobe");
    a_tick_nesting: assert property (tick_25 || tick_10 |-> tick_125)
        else $error("slow strobe without reference phase");
    a_rx_withheld: assert property (gig && mac_rx_valid |-> $past(hunt_r) == H_LOCKED)
        else $error("gigabit data passed before lock");

    c_gig_lock: cover property ($rose(gig_locked));
    c_inverted_sfd: cover property (rx10_r == R_HUNT && bit_en && carrier && sh_nxt == SFD_INVERTED);
    c_fifo_full: cover property (!mac_tx_ready);
    c_auto_xover: cover property (!gig && $rose(auto_x_r));
endmodule

// File: dv/far_phy_model.sv
// far-side phy model: sends one slow frame, preamble, delimiter, two bytes
// assumes one bit per five core_clk cycles, counted from reset release
`timescale 1ns/1ps
module far_phy_model
    import phy_pair_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        invert,
    input  wire logic [15:0] payload,
    output logic      [2:0]  line_level
);
    logic [2:0] phase_r;
    logic [6:0] bit_r;
    logic       busy_r;
    logic [7:0] byte_now;
    // byte under transmission, bits go out lsb first
    assign byte_now = (bit_r < 7'h38) ? 8'h55 : (bit_r < 7'h40) ? SFD_BYTE :
                      (bit_r < 7'h48) ? payload[7:0] : payload[15:8];
    // levels change mid-bit so the far strobe never races an edge
    always_ff @(posedge core_clk) begin
        phase_r <= (rst || phase_r == 3'h4) ? 3'h0 : phase_r + 3'h1;
        if (rst) begin
            busy_r     <= 1'b0;
            line_level <= LVL_MID;
        end else if (phase_r == 3'h2) begin
            if (busy_r && bit_r == 7'h50) begin
                busy_r     <= 1'b0;
                line_level <= LVL_MID;
            end else if (busy_r) begin
                line_level <= (byte_now[bit_r[2:0]] ^ invert) ? LVL_HI : LVL_LO;
                bit_r      <= bit_r + 7'h01;
            end else if (start) begin
                busy_r <= 1'b1;
                bit_r  <= 7'h00;
            end
        end
    end
endmodule

// File: dv/phy_pair_core_test.sv
// bench for the pair mapping core: slow tx/rx, auto crossover, fifo, gig hold-off
// assumes the far-side model in far_phy_model and the shared package
`timescale 1ns/1ps
module phy_pair_core_test;
    import phy_pair_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    logic       pll_tick = 1'b1;
    logic [1:0] speed    = SPEED_100;
    logic       rx_sym_tick = 1'b0;
    logic       xoff     = 1'b1;
    logic       force_xo = 1'b0;
    logic       tx_valid = 1'b0;
    logic [7:0] tx_data  = 8'h00;
    logic       start    = 1'b0;
    logic       invert   = 1'b0;
    logic       route_one = 1'b0;
    logic       noise    = 1'b0;
    logic       is_slave = 1'b0;
    logic [15:0] payload = 16'h0000;
    logic [2:0] far_lvl, p1, p2, p3, p4, r1, r2;
    logic       tx_ready, rx_valid, rx_tick, xo_act, locked;
    logic [7:0] rx_data;
    int         n_mismatch = 0;
    int         check_count = 0;
    localparam logic [7:0] TX_BYTE = 8'ha5;
    // far level on one pair, the other pairs rest at zero level
    assign r1 = noise ? 3'h7 : route_one ? far_lvl : LVL_MID;
    assign r2 = noise ? 3'h7 : route_one ? LVL_MID : far_lvl;
    always #25 core_clk = ~core_clk;
    phy_pair_core #(.FIFO_DEPTH(32)) i_dut (.core_clk(core_clk), .rst(rst),
        .pll_tick(pll_tick), .speed(speed), .is_slave(is_slave), .phy_addr(5'h03),
        .auto_xover_off(xoff), .force_xover(force_xo), .rx_sym_tick(rx_sym_tick),
        .line_pair_one_rx(r1), .line_pair_two_rx(r2), .line_pair_three_rx(noise ? 3'h7 : LVL_MID),
        .line_pair_four_rx(noise ? 3'h7 : LVL_MID), .line_pair_one_tx(p1), .line_pair_two_tx(p2),
        .line_pair_three_tx(p3), .line_pair_four_tx(p4), .mac_tx_valid(tx_valid),
        .mac_tx_data(tx_data), .mac_tx_ready(tx_ready), .mac_rx_valid(rx_valid),
        .mac_rx_data(rx_data), .mac_rx_clk_tick(rx_tick), .xover_active(xo_act),
        .gig_locked(locked));
    far_phy_model i_far (.core_clk(core_clk), .rst(rst), .start(start), .invert(invert),
        .payload(payload), .line_level(far_lvl));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [2:0] pick(input logic x);
        return x ? p2 : p1;
    endfunction
    task automatic test_reset();
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        check("tx_lines", {p1, p2, 2'h0}, {LVL_MID, LVL_MID, 2'h0});
        check("rx_out", {rx_valid, rx_tick, xo_act, locked, tx_ready}, 8'h01);
        @(posedge core_clk);
        rst <= 1'b0;
    endtask
    // forced mapping, one byte out lsb first on the selected pair
    task automatic test_tx(input logic xo);
        @(posedge core_clk);
        force_xo <= xo;
        for (int i = 0; i < 20 && pick(xo) !== LVL_MID; i++) @(posedge core_clk);
        tx_valid <= 1'b1;
        tx_data  <= TX_BYTE;
        @(posedge core_clk);
        tx_valid <= 1'b0;
        for (int i = 0; i < 40 && pick(xo) === LVL_MID; i++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        check("xover", {7'h0, xo_act}, {7'h0, xo});
        for (int b = 0; b < 8; b++) begin
            check("tx_bit", {5'h0, pick(xo)}, {5'h0, TX_BYTE[b] ? LVL_HI : LVL_LO});
            check("tx_rest", {2'h0, pick(!xo), p3 | p4}, {2'h0, LVL_MID, LVL_MID});
            repeat (5) @(negedge core_clk);
        end
    endtask
    // auto mapping follows the far pair; frame starts at the delimiter
    task automatic test_rx(input logic one, input logic inv, input logic [15:0] pay);
        @(posedge core_clk);
        xoff      <= 1'b0;
        route_one <= one;
        invert    <= inv;
        payload   <= pay;
        start     <= 1'b1;
        repeat (6) @(posedge core_clk);
        start <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 600 && rx_valid !== 1'b1; i++) @(negedge core_clk);
            check("rx_byte", rx_data, k == 0 ? SFD_BYTE : k == 1 ? pay[7:0] : pay[15:8]);
            @(negedge core_clk);
        end
        check("auto_xover", {7'h0, xo_act}, {7'h0, one});
        repeat (60) @(posedge core_clk);
    endtask
    task automatic test_idle_clock();
        logic [7:0] n;
        n = 8'h00;
        repeat (50) begin
            @(negedge core_clk);
            n = n + {7'h0, rx_tick};
        end
        check("rx_clk_idle", n, 8'h0a);
    endtask
    // illegal symbols never lock; second half as slave, lines move only on the strobe
    task automatic test_gig_withheld();
        logic [7:0]  n;
        logic [7:0]  moved;
        logic [11:0] last;
        logic        was;
        n     = 8'h00;
        moved = 8'h00;
        last  = 12'h000;
        @(posedge core_clk);
        speed <= SPEED_1000;
        noise <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge core_clk);
            was = rx_sym_tick;
            rx_sym_tick <= ~rx_sym_tick;
            is_slave    <= (i >= 50);
            @(negedge core_clk);
            n = n | {6'h0, locked, rx_valid};
            if (i >= 52 && !was && {p1, p2, p3, p4} !== last) moved = moved + 8'h01;
            last = {p1, p2, p3, p4};
        end
        check("gig_hold", n, 8'h00);
        check("slave_tx", moved, 8'h00);
        @(posedge core_clk);
        is_slave    <= 1'b0;
        speed       <= SPEED_100;
        noise       <= 1'b0;
        rx_sym_tick <= 1'b0;
    endtask
    // fill with the bit strobe stalled, then let it drain to idle
    task automatic test_fifo();
        logic [7:0] n;
        logic [7:0] run;
        n   = 8'h00;
        run = 8'h00;
        @(posedge core_clk);
        xoff     <= 1'b1;
        force_xo <= 1'b0;
        pll_tick <= 1'b0;
        tx_valid <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            tx_data <= 8'(i);
            @(negedge core_clk);
            if (tx_ready !== 1'b1) break;
            n = n + 8'h01;
            @(posedge core_clk);
        end
        @(posedge core_clk);
        tx_valid <= 1'b0;
        pll_tick <= 1'b1;
        check("fifo_fill", n, 8'h20);
        for (int i = 0; i < 20 && tx_ready !== 1'b1; i++) @(negedge core_clk);
        check("fifo_pop", {7'h0, tx_ready}, 8'h01);
        for (int i = 0; i < 3000 && run != 8'h0c; i++) begin
            @(negedge core_clk);
            run = (p1 === LVL_MID) ? run + 8'h01 : 8'h00;
        end
        check("fifo_drain", run, 8'h0c);
    endtask
    initial begin
        test_reset();
        test_tx(1'b0);
        test_tx(1'b1);
        test_rx(1'b0, 1'b0, 16'h3c81);
        test_idle_clock();
        test_rx(1'b1, 1'b1, 16'h7e18);
        test_gig_withheld();
        test_fifo();
        final_report();
    end
    // hang guard, about seven times the expected run
    initial begin
        #(20000 * 50);
        n_mismatch++;
        final_report();
    end
endmodule
